// ===== logic/tfd_addr_match.sv
// address decoder: maps configuration and host address onto a register offset
`timescale 1ns/100ps
`default_nettype none
`include "tfd_consts.svh"
module tfd_addr_match (
  input wire logic [1:0] cfg_in,
  input wire logic [9:0] addr_in,
  output logic hit_out,
  output logic [3:0] off_out
);
  logic [5:0] task_base;
  logic [5:0] ctl_base;
  // fixed block bases by configuration
  always_comb begin
    task_base = (cfg_in == `TFD_CFG_PRIMARY) ? `TFD_PRI_TASK_BASE : `TFD_SEC_TASK_BASE;
    ctl_base = (cfg_in == `TFD_CFG_PRIMARY) ? `TFD_PRI_CTL_BASE : `TFD_SEC_CTL_BASE;
  end
  // decode per configuration
  always_comb begin
    hit_out = 1'b0;
    off_out = addr_in[3:0];
    case (cfg_in)
      `TFD_CFG_CONTIG: begin
        hit_out = 1'b1;
      end
      `TFD_CFG_PRIMARY, `TFD_CFG_SECONDARY: begin
        if (addr_in[9:4] == task_base && !addr_in[3]) begin
          hit_out = 1'b1;
          off_out = {1'b0, addr_in[2:0]};
        end else if (addr_in[9:4] == ctl_base && addr_in[3:1] == `TFD_CTL_SUB) begin
          hit_out = 1'b1;
          off_out = {3'h7, addr_in[0]};
        end
      end
      default: begin
        hit_out = 1'b0; // memory window is not an i/o decode
      end
    endcase
  end
endmodule : tfd_addr_match
`default_nettype wire

// ===== logic/tfd_consts.svh
// task file decoder offsets, configuration indices, address bases and reset values
`ifndef TFD_CONSTS_SVH
`define TFD_CONSTS_SVH
// register offsets within the sixteen-entry window
`define TFD_OFF_DATA 4'h0
`define TFD_OFF_ERR_FEAT 4'h1
`define TFD_OFF_SEC_CNT 4'h2
`define TFD_OFF_SEC_NUM 4'h3
`define TFD_OFF_CYL_LO 4'h4
`define TFD_OFF_CYL_HI 4'h5
`define TFD_OFF_CARD_HEAD 4'h6
`define TFD_OFF_STAT_CMD 4'h7
`define TFD_OFF_DUP_EVEN 4'h8
`define TFD_OFF_DUP_ODD 4'h9
`define TFD_OFF_DUP_ERR_FEAT 4'hd
`define TFD_OFF_ALT_STAT_CTL 4'he
`define TFD_OFF_DRIVE_ADDR 4'hf
// configuration index values
`define TFD_CFG_MEMORY 2'h0
`define TFD_CFG_CONTIG 2'h1
`define TFD_CFG_PRIMARY 2'h2
`define TFD_CFG_SECONDARY 2'h3
// address bits 9..4 of the fixed task file and control blocks
`define TFD_PRI_TASK_BASE 6'h1f
`define TFD_PRI_CTL_BASE 6'h3f
`define TFD_SEC_TASK_BASE 6'h17
`define TFD_SEC_CTL_BASE 6'h37
// control block occupies offsets 6 and 7 of its block (bits 3..1 = 3'b011)
`define TFD_CTL_SUB 3'h3
// reset values
`define TFD_RST_BYTE 8'h00
`define TFD_RST_WORD 16'h0000
`endif

// ===== logic/tfd_data_buf.sv
// sector data buffer with host-side byte and word sequencing
`timescale 1ns/100ps
`default_nettype none
`include "tfd_consts.svh"
module tfd_data_buf #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic op_word_in,
  input wire logic op_seq_in,
  input wire logic op_odd_in,
  input wire logic op_wr_in,
  input wire logic [15:0] wdata_in,
  input wire logic restart_in,
  input wire logic core_we_in,
  input wire logic [AW-1:0] core_idx_in,
  input wire logic [15:0] core_wdata_in,
  output logic [15:0] core_rdata_out,
  output logic [15:0] cur_word_out,
  output logic even_done_out,
  output logic [AW-1:0] ptr_out
);
  logic [15:0] mem_reg [DEPTH];
  logic [AW-1:0] ptr_reg, ptr_next;
  logic even_reg, even_next, odd_reg, odd_next;
  logic [15:0] core_rdata_reg;
  logic host_we;
  logic [1:0] lane_we;

  assign host_we = op_wr_in && (op_word_in || op_seq_in || op_odd_in);
  // byte lanes written by the host this cycle
  always_comb begin
    lane_we = 2'h0;
    if (op_word_in) begin
      lane_we = 2'h3;
    end else if (op_seq_in) begin
      lane_we = even_reg ? 2'h2 : 2'h1;
    end else if (op_odd_in) begin
      lane_we = 2'h2;
    end
  end
  // storage entries; host write wins over core write at the same entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    logic [15:0] ent_next;
    always_comb begin
      ent_next = mem_reg[i];
      if (host_we && ptr_reg == AW'(i)) begin
        if (lane_we[0]) ent_next[7:0] = op_odd_in ? ent_next[7:0] : wdata_in[7:0];
        if (lane_we[1]) ent_next[15:8] = op_word_in ? wdata_in[15:8] : wdata_in[7:0]; // byte ops carry on low bits
      end else if (core_we_in && core_idx_in == AW'(i)) begin
        ent_next = core_wdata_in;
      end
    end
    always_ff @(posedge clk_in) begin
      if (!rstn_in) mem_reg[i] <= `TFD_RST_WORD;
      else mem_reg[i] <= ent_next;
    end
  end
  // pointer and byte-phase sequencing
  always_comb begin
    ptr_next = ptr_reg;
    even_next = even_reg;
    odd_next = odd_reg;
    if (restart_in) begin
      ptr_next = '0;
      even_next = 1'b0;
      odd_next = 1'b0;
    end else if (op_word_in) begin
      ptr_next = ptr_reg + 1'b1;
      even_next = 1'b0;
      odd_next = 1'b0;
    end else if (op_seq_in || op_odd_in) begin
      if (op_seq_in && !even_reg) even_next = 1'b1;
      else odd_next = 1'b1;
      if ((even_next && odd_next)) begin
        ptr_next = ptr_reg + 1'b1;
        even_next = 1'b0;
        odd_next = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ptr_reg <= '0;
      even_reg <= 1'b0;
      odd_reg <= 1'b0;
      core_rdata_reg <= `TFD_RST_WORD;
    end else begin
      ptr_reg <= ptr_next;
      even_reg <= even_next;
      odd_reg <= odd_next;
      core_rdata_reg <= mem_reg[core_idx_in];
    end
  end
  assign cur_word_out = mem_reg[ptr_reg];
  assign even_done_out = even_reg;
  assign ptr_out = ptr_reg;
  assign core_rdata_out = core_rdata_reg;
endmodule : tfd_data_buf
`default_nettype wire

// ===== logic/tfd_pkg.sv
// types shared by the task file decoder modules
package tfd_pkg;
  // one decoded host access
  typedef struct packed {
    logic hit;
    logic rd;
    logic wr;
    logic lo;
    logic hi;
    logic [3:0] off;
  } tfd_access_t;
  // writable task file contents seen by the command engine
  typedef struct packed {
    logic [7:0] features;
    logic [7:0] sector_count;
    logic [7:0] sector_number;
    logic [7:0] cylinder_low;
    logic [7:0] cylinder_high;
    logic [7:0] card_head_select;
    logic [7:0] command;
    logic [7:0] device_control;
  } tfd_taskfile_t;
endpackage : tfd_pkg

// ===== logic/tfd_task_file_io.sv
// host i/o window of the task file: decode, byte steering and data buffer access
//
// Overview of operation
// - primary config decodes task file 1F0h-1F7h and control at 3F6h-3F7h.
// - secondary config decodes task file 170h-177h and control at 376h-377h.
// - contiguous config answers anywhere, register picked by the four low address bits.
// - contiguous decode ignores all other address lines except register-space select.
// - configuration index 0 memory, 1 contiguous, 2 primary, 3 secondary.
// - offsets 0 data,1 error/features,2-6 task file,7 status/command.
// - word access at offset 0 moves the whole data word; with A0 high the offset is 1 or 9 instead.
// - two low-byte accesses at offset 0 give even byte then odd byte.
// - high-only byte access at offset 0 reaches error/features on upper lanes.
// - offsets 8, 9, D duplicate data, odd data byte and error/features.
// - byte access to 9 then 8 gives odd byte first, even byte second.
// - repeated byte accesses at 8 or 0 step through buffer even then odd.
// - each word access at 8, 9 or 0 advances the buffer one word.
// - host never repeats byte accesses at 9; alternating 8,9 walks the buffer.
// - word port indicator asserted for every i/o address the card answers.
`timescale 1ns/100ps
`default_nettype none
`include "tfd_consts.svh"
module tfd_task_file_io #(
  parameter int BUF_DEPTH = 256,
  parameter int BUF_AW = 8
) (
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic [1:0] CONFIG_INDEX_IN,
  input wire logic REG_SPACE_N_IN,
  input wire logic LOW_BYTE_CARD_ENABLE_N_IN,
  input wire logic HIGH_BYTE_CARD_ENABLE_N_IN,
  input wire logic [9:0] ADDR_IN,
  input wire logic IO_READ_STROBE_N_IN,
  input wire logic IO_WRITE_STROBE_N_IN,
  input wire logic [15:0] DATA_IN,
  output logic [15:0] DATA_OUT,
  output logic [1:0] DATA_OE_OUT,
  output logic WORD_PORT_INDICATOR_N_OUT,
  input wire logic [7:0] ERROR_IN,
  input wire logic [7:0] STATUS_IN,
  input wire logic [7:0] DRIVE_ADDR_IN,
  output tfd_pkg::tfd_taskfile_t TASK_FILE_OUT,
  output logic COMMAND_STROBE_OUT,
  input wire logic CORE_BUF_WE_IN,
  input wire logic [BUF_AW-1:0] CORE_BUF_IDX_IN,
  input wire logic [15:0] CORE_BUF_WDATA_IN,
  output logic [15:0] CORE_BUF_RDATA_OUT,
  output logic [BUF_AW-1:0] HOST_WORD_INDEX_OUT
);
  import tfd_pkg::*;

  tfd_access_t acc;
  logic match_hit;
  logic [3:0] match_off;
  logic [3:0] eff_off;
  logic strobe_on, start;
  logic active_reg, active_next;
  logic op_word, op_seq, op_odd, is_data;
  logic [15:0] cur_word;
  logic even_done;
  logic [BUF_AW-1:0] host_ptr;
  tfd_taskfile_t tf_reg, tf_next;
  logic cmd_reg, cmd_next;
  logic [15:0] dout_reg, dout_next;
  logic [1:0] oe_reg, oe_next;
  logic io16_n_reg, io16_n_next;
  logic [7:0] lo_rd, hi_rd;

  // register offset from configuration and address
  tfd_addr_match u_match (
    .cfg_in(CONFIG_INDEX_IN),
    .addr_in(ADDR_IN),
    .hit_out(match_hit),
    .off_out(match_off)
  );

  // access qualification and start-of-strobe detection
  always_comb begin
    acc.lo = !LOW_BYTE_CARD_ENABLE_N_IN;
    acc.hi = !HIGH_BYTE_CARD_ENABLE_N_IN;
    acc.rd = !IO_READ_STROBE_N_IN && IO_WRITE_STROBE_N_IN;
    acc.wr = !IO_WRITE_STROBE_N_IN && IO_READ_STROBE_N_IN;
    acc.hit = match_hit && !REG_SPACE_N_IN && (acc.lo || acc.hi);
    acc.off = match_off;
    strobe_on = acc.hit && (acc.rd || acc.wr);
    start = strobe_on && !active_reg;
    active_next = strobe_on;
  end

  // high-only byte access goes to the odd register of the pair
  assign eff_off = (acc.hi && !acc.lo) ? {acc.off[3:1], 1'b1} : acc.off;

  // data register access kinds
  always_comb begin
    is_data = (acc.off == `TFD_OFF_DATA) || (acc.off == `TFD_OFF_DUP_EVEN);
    op_word = start && acc.lo && acc.hi && (is_data || acc.off == `TFD_OFF_DUP_ODD);
    op_seq = start && acc.lo && !acc.hi && is_data;
    op_odd = start && !(acc.lo && acc.hi) && (eff_off == `TFD_OFF_DUP_ODD);
  end

  tfd_data_buf #(
    .DEPTH(BUF_DEPTH),
    .AW(BUF_AW)
  ) u_buf (
    .clk_in(CLOCK_IN),
    .rstn_in(RSTN_IN),
    .op_word_in(op_word),
    .op_seq_in(op_seq),
    .op_odd_in(op_odd),
    .op_wr_in(acc.wr),
    .wdata_in(acc.lo ? DATA_IN : {DATA_IN[15:8], DATA_IN[15:8]}),
    .restart_in(cmd_next),
    .core_we_in(CORE_BUF_WE_IN),
    .core_idx_in(CORE_BUF_IDX_IN),
    .core_wdata_in(CORE_BUF_WDATA_IN),
    .core_rdata_out(CORE_BUF_RDATA_OUT),
    .cur_word_out(cur_word),
    .even_done_out(even_done),
    .ptr_out(host_ptr)
  );

  // read value of a byte register at an offset
  function automatic logic [7:0] reg_read(input logic [3:0] off, input tfd_taskfile_t tf);
    logic [7:0] val;
    val = 8'h00;
    case (off)
      `TFD_OFF_ERR_FEAT, `TFD_OFF_DUP_ERR_FEAT: val = ERROR_IN;
      `TFD_OFF_SEC_CNT: val = tf.sector_count;
      `TFD_OFF_SEC_NUM: val = tf.sector_number;
      `TFD_OFF_CYL_LO: val = tf.cylinder_low;
      `TFD_OFF_CYL_HI: val = tf.cylinder_high;
      `TFD_OFF_CARD_HEAD: val = tf.card_head_select;
      `TFD_OFF_STAT_CMD, `TFD_OFF_ALT_STAT_CTL: val = STATUS_IN;
      `TFD_OFF_DRIVE_ADDR: val = DRIVE_ADDR_IN;
      default: val = 8'h00;
    endcase
    return val;
  endfunction : reg_read

  // byte-register reads for the two lanes
  always_comb begin
    lo_rd = reg_read(acc.off, tf_reg);
    hi_rd = reg_read({acc.off[3:1], 1'b1}, tf_reg);
  end

  // task file writes and command strobe
  always_comb begin
    tf_next = tf_reg;
    cmd_next = 1'b0;
    if (start && acc.wr) begin
      if (acc.lo) begin
        case (acc.off)
          `TFD_OFF_ERR_FEAT, `TFD_OFF_DUP_ERR_FEAT: tf_next.features = DATA_IN[7:0];
          `TFD_OFF_SEC_CNT: tf_next.sector_count = DATA_IN[7:0];
          `TFD_OFF_SEC_NUM: tf_next.sector_number = DATA_IN[7:0];
          `TFD_OFF_CYL_LO: tf_next.cylinder_low = DATA_IN[7:0];
          `TFD_OFF_CYL_HI: tf_next.cylinder_high = DATA_IN[7:0];
          `TFD_OFF_CARD_HEAD: tf_next.card_head_select = DATA_IN[7:0];
          `TFD_OFF_STAT_CMD: begin
            tf_next.command = DATA_IN[7:0];
            cmd_next = 1'b1;
          end
          `TFD_OFF_ALT_STAT_CTL: tf_next.device_control = DATA_IN[7:0];
          default: tf_next = tf_next;
        endcase
      end
      if (acc.hi && !(acc.lo && is_data)) begin
        case ({acc.off[3:1], 1'b1}) // high lane always reaches the odd register of the pair
          `TFD_OFF_ERR_FEAT, `TFD_OFF_DUP_ERR_FEAT: tf_next.features = DATA_IN[15:8];
          `TFD_OFF_SEC_NUM: tf_next.sector_number = DATA_IN[15:8];
          `TFD_OFF_CYL_HI: tf_next.cylinder_high = DATA_IN[15:8];
          `TFD_OFF_STAT_CMD: begin
            tf_next.command = DATA_IN[15:8];
            cmd_next = 1'b1;
          end
          default: tf_next = tf_next;
        endcase
      end
    end
  end

  // read data capture and lane enables
  always_comb begin
    dout_next = dout_reg;
    oe_next = 2'h0;
    if (strobe_on && acc.rd) begin
      oe_next = {acc.hi, acc.lo}; // only selected lanes driven
      if (start) begin
        if (op_word) begin
          dout_next = cur_word;
        end else if (op_seq) begin
          dout_next = {8'h00, even_done ? cur_word[15:8] : cur_word[7:0]};
        end else if (op_odd) begin
          dout_next = acc.lo ? {8'h00, cur_word[15:8]} : {cur_word[15:8], 8'h00};
        end else if (acc.lo) begin
          dout_next = {acc.hi ? hi_rd : 8'h00, lo_rd};
        end else begin
          dout_next = {hi_rd, 8'h00};
        end
      end
    end
  end

  // 16-bit port indication whenever an i/o address is decoded
  assign io16_n_next = !acc.hit;

  // register all outputs
  always_ff @(posedge CLOCK_IN) begin
    if (!RSTN_IN) begin
      active_reg <= 1'b0;
      tf_reg <= '0;
      cmd_reg <= 1'b0;
      dout_reg <= `TFD_RST_WORD;
      oe_reg <= 2'h0;
      io16_n_reg <= 1'b1;
    end else begin
      active_reg <= active_next;
      tf_reg <= tf_next;
      cmd_reg <= cmd_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      io16_n_reg <= io16_n_next;
    end
  end

  assign DATA_OUT = dout_reg;
  assign DATA_OE_OUT = oe_reg;
  assign WORD_PORT_INDICATOR_N_OUT = io16_n_reg;
  assign TASK_FILE_OUT = tf_reg;
  assign COMMAND_STROBE_OUT = cmd_reg;
  assign HOST_WORD_INDEX_OUT = host_ptr;
endmodule : tfd_task_file_io
`default_nettype wire

// ===== tb/tfd_host_model.sv
// host bus controller model driving i/o strobe cycles
`timescale 1ns/100ps
`default_nettype none
module tfd_host_model (
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic reg_n_out,
  output logic lo_n_out,
  output logic hi_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [9:0] addr_out,
  output logic [15:0] wdata_out
);
  logic inhibit = 1'b0;
  // idle bus at time zero
  initial begin
    {reg_n_out, lo_n_out, hi_n_out, rd_n_out, wr_n_out} = 5'h1f;
    addr_out = 10'h000;
    wdata_out = 16'h0000;
  end
  // one slow standard-timing cycle only, single card, no advanced mode
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [1:0] en_n, input logic [15:0] d,
    output logic [15:0] q);
    @(posedge clk_in);
    #1;
    reg_n_out = inhibit;
    {hi_n_out, lo_n_out} = en_n;
    addr_out = a;
    wdata_out = d;
    rd_n_out = wr;
    wr_n_out = !wr;
    repeat (2) @(posedge clk_in);
    q = rdata_in;
    #1;
    {reg_n_out, lo_n_out, hi_n_out, rd_n_out, wr_n_out} = 5'h1f;
    wdata_out = ~d; // released lines show the inverse
    addr_out = ~a;
  endtask : xfer
endmodule : tfd_host_model
`default_nettype wire

// ===== tb/tfd_task_file_io_asserts.sv
// checker for the task file i/o window ports
`timescale 1ns/100ps
`default_nettype none
`include "tfd_consts.svh"
module tfd_task_file_io_asserts #(
  parameter int BUF_AW = 8
) (
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic [1:0] CONFIG_INDEX_IN,
  input wire logic REG_SPACE_N_IN,
  input wire logic LOW_BYTE_CARD_ENABLE_N_IN,
  input wire logic HIGH_BYTE_CARD_ENABLE_N_IN,
  input wire logic [9:0] ADDR_IN,
  input wire logic IO_READ_STROBE_N_IN,
  input wire logic IO_WRITE_STROBE_N_IN,
  input wire logic [1:0] DATA_OE_OUT,
  input wire logic WORD_PORT_INDICATOR_N_OUT,
  input wire logic COMMAND_STROBE_OUT,
  input wire logic [BUF_AW-1:0] HOST_WORD_INDEX_OUT
);
  logic ctl, hit, en, sel, sel_prev, start;
  logic [3:0] off;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RSTN_IN);
  // reference decode of address, enables and strobes
  always_comb begin
    ctl = ADDR_IN[3:1] == `TFD_CTL_SUB;
    ctl = ctl && ADDR_IN[9:4] == (CONFIG_INDEX_IN[0] ? `TFD_SEC_CTL_BASE : `TFD_PRI_CTL_BASE);
    hit = !ADDR_IN[3] && ADDR_IN[9:4] == (CONFIG_INDEX_IN[0] ? `TFD_SEC_TASK_BASE : `TFD_PRI_TASK_BASE);
    hit = CONFIG_INDEX_IN == `TFD_CFG_CONTIG || (CONFIG_INDEX_IN[1] && (ctl || hit));
    off = (CONFIG_INDEX_IN[1] && ctl) ? {1'b1, ADDR_IN[2:0]} : ADDR_IN[3:0];
    en = !REG_SPACE_N_IN && !(LOW_BYTE_CARD_ENABLE_N_IN && HIGH_BYTE_CARD_ENABLE_N_IN);
    sel = en && hit && (IO_READ_STROBE_N_IN != IO_WRITE_STROBE_N_IN);
  end
  // first cycle of an access
  always_ff @(posedge CLOCK_IN) sel_prev <= RSTN_IN && sel;
  assign start = sel && !sel_prev;
  sequence s_rd_start;
    start && !IO_READ_STROBE_N_IN;
  endsequence
  sequence s_word_data;
    s_rd_start ##0 (!LOW_BYTE_CARD_ENABLE_N_IN && !HIGH_BYTE_CARD_ENABLE_N_IN && off inside {4'h0, 4'h8, 4'h9});
  endsequence
  sequence s_cmd_wr;
    start && !IO_WRITE_STROBE_N_IN && !LOW_BYTE_CARD_ENABLE_N_IN && off == `TFD_OFF_STAT_CMD;
  endsequence
  a_oe_needs_read: assert property (DATA_OE_OUT != 2'h0 |-> $past(!IO_READ_STROBE_N_IN))
    else $error("data driven without a read strobe");
  a_ignore_unselected: assert property ($past(!(en && hit)) |-> DATA_OE_OUT == 2'h0)
    else $error("data driven for an ignored cycle");
  a_oe_lane_match: assert property (s_rd_start |=> DATA_OE_OUT == ~$past({HIGH_BYTE_CARD_ENABLE_N_IN,
    LOW_BYTE_CARD_ENABLE_N_IN}))
    else $error("driven lanes differ from enables");
  a_word_ind_on: assert property ($past(RSTN_IN && en && hit) |-> !WORD_PORT_INDICATOR_N_OUT)
    else $error("word port indicator missing");
  a_word_ind_off: assert property ($past(!(en && hit)) |-> WORD_PORT_INDICATOR_N_OUT)
    else $error("word port indicator without decode");
  a_cmd_pulse: assert property (s_cmd_wr |=> COMMAND_STROBE_OUT ##1 !COMMAND_STROBE_OUT)
    else $error("command strobe not a single pulse");
  a_cmd_cause: assert property (COMMAND_STROBE_OUT |-> $past(start && !IO_WRITE_STROBE_N_IN &&
    {off[3:1], off[0] || !HIGH_BYTE_CARD_ENABLE_N_IN} == 4'h7))
    else $error("command strobe without command write");
  a_cmd_rewind: assert property (COMMAND_STROBE_OUT |-> HOST_WORD_INDEX_OUT == '0)
    else $error("pointer not rewound by command");
  a_word_step: assert property (s_word_data |=> HOST_WORD_INDEX_OUT == $past(HOST_WORD_INDEX_OUT) + 1'b1)
    else $error("word access did not advance one word");
endmodule : tfd_task_file_io_asserts
bind tfd_task_file_io tfd_task_file_io_asserts #(.BUF_AW(BUF_AW)) tfd_task_file_io_asserts_i (.CLOCK_IN,
  .RSTN_IN, .CONFIG_INDEX_IN, .REG_SPACE_N_IN, .LOW_BYTE_CARD_ENABLE_N_IN, .HIGH_BYTE_CARD_ENABLE_N_IN,
  .ADDR_IN, .IO_READ_STROBE_N_IN, .IO_WRITE_STROBE_N_IN, .DATA_OE_OUT, .WORD_PORT_INDICATOR_N_OUT,
  .COMMAND_STROBE_OUT, .HOST_WORD_INDEX_OUT);
`default_nettype wire

// ===== tb/tfd_task_file_io_tb_top.sv
// self-checking testbench of the task file i/o window
`timescale 1ns/100ps
`default_nettype none
`include "tfd_consts.svh"
module tfd_task_file_io_tb_top;
  import tfd_pkg::*;
  logic clk, rstn, core_we, reg_n, lo_n, hi_n, rd_n, wr_n, ind_n, cmd_stb;
  logic [1:0] cfg, oe;
  logic [3:0] core_idx, ptr;
  logic [7:0] err_v, stat_v, drv_v;
  logic [9:0] addr, tb, cb;
  logic [15:0] wdata, dout, core_wd, core_rd, w;
  tfd_taskfile_t tf;
  int err_total, n_compared;
  tfd_host_model tfd_host_model_i (.clk_in(clk), .rdata_in(dout), .reg_n_out(reg_n), .lo_n_out(lo_n),
    .hi_n_out(hi_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(addr), .wdata_out(wdata));
  tfd_task_file_io #(.BUF_DEPTH(16), .BUF_AW(4)) tfd_task_file_io_i (.CLOCK_IN(clk), .RSTN_IN(rstn),
    .CONFIG_INDEX_IN(cfg), .REG_SPACE_N_IN(reg_n), .LOW_BYTE_CARD_ENABLE_N_IN(lo_n),
    .HIGH_BYTE_CARD_ENABLE_N_IN(hi_n), .ADDR_IN(addr), .IO_READ_STROBE_N_IN(rd_n),
    .IO_WRITE_STROBE_N_IN(wr_n), .DATA_IN(wdata), .DATA_OUT(dout), .DATA_OE_OUT(oe),
    .WORD_PORT_INDICATOR_N_OUT(ind_n), .ERROR_IN(err_v), .STATUS_IN(stat_v), .DRIVE_ADDR_IN(drv_v),
    .TASK_FILE_OUT(tf), .COMMAND_STROBE_OUT(cmd_stb), .CORE_BUF_WE_IN(core_we), .CORE_BUF_IDX_IN(core_idx),
    .CORE_BUF_WDATA_IN(core_wd), .CORE_BUF_RDATA_OUT(core_rd), .HOST_WORD_INDEX_OUT(ptr));
  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : check_val
  task automatic wr(input logic [9:0] a, input logic [1:0] en_n, input logic [15:0] d);
    logic [15:0] q;
    tfd_host_model_i.xfer(1'b1, a, en_n, d, q);
  endtask : wr
  task automatic rd_chk(input logic [9:0] a, input logic [1:0] en_n, input logic [15:0] exp);
    logic [15:0] q;
    tfd_host_model_i.xfer(1'b0, a, en_n, 16'h0000, q);
    check_val(q, exp);
    check_val(16'({oe, ind_n}), 16'({~en_n, 1'b0}));
  endtask : rd_chk
  // core side buffer access
  task automatic core_io(input logic we, input logic [3:0] idx, input logic [15:0] d);
    @(posedge clk);
    #1;
    core_we = we;
    core_idx = idx;
    core_wd = d;
    @(posedge clk);
    #1;
    core_we = 1'b0;
    @(posedge clk);
  endtask : core_io
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // watchdog
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
  function automatic logic [15:0] wv(input int i);
    return {8'(8'ha0 + i), 8'(8'h50 + i)};
  endfunction : wv
  // main sequence
  initial begin
    {rstn, core_we, core_idx, core_wd, cfg} = '0;
    {err_v, stat_v, drv_v} = 24'h5a50c3;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    check_val(16'(|tf), 16'h0000);
    check_val(16'(ptr), 16'h0000);
    for (int c = 1; c < 4; c++) begin
      cfg = 2'(c);
      tb = (c == 1) ? 10'h2c0 : (c == 2) ? 10'h1f0 : 10'h170;
      cb = (c == 1) ? 10'h2c8 : (c == 2) ? 10'h3f0 : 10'h370;
      for (int o = 2; o < 7; o++) wr(tb + 10'(o), 2'h2, 16'(16 * c + o));
      for (int o = 2; o < 7; o++) rd_chk(tb + 10'(o), 2'h2, 16'(16 * c + o));
      rd_chk(tb + 10'h1, 2'h2, {8'h00, err_v});
      rd_chk(tb + 10'h7, 2'h2, {8'h00, stat_v});
      rd_chk(cb + 10'h6, 2'h2, {8'h00, stat_v});
      rd_chk(cb + 10'h7, 2'h2, {8'h00, drv_v});
      wr(cb + 10'h6, 2'h2, 16'(c));
      check_val(16'(tf.device_control), 16'(c));
    end
    // ignored cycles leave the task file alone
    wr(10'h1f2, 2'h2, 16'h00ee);
    cfg = `TFD_CFG_MEMORY;
    wr(10'h172, 2'h2, 16'h00ee);
    cfg = `TFD_CFG_SECONDARY;
    tfd_host_model_i.inhibit = 1'b1;
    wr(10'h172, 2'h2, 16'h00ee);
    tfd_host_model_i.inhibit = 1'b0;
    check_val(16'(tf.sector_count), 16'h0032);
    cfg = `TFD_CFG_CONTIG;
    rd_chk(10'h3d2, 2'h2, 16'h0032);
    // data buffer sequencing
    for (int i = 0; i < 8; i++) core_io(1'b1, 4'(i), wv(i));
    wr(10'h007, 2'h2, 16'h0020);
    check_val(16'(tf.command), 16'h0020);
    rd_chk(10'h000, 2'h0, wv(0));
    rd_chk(10'h008, 2'h0, wv(1));
    rd_chk(10'h009, 2'h0, wv(2));
    for (int i = 3; i < 7; i++) begin
      w = wv(i);
      rd_chk(i == 5 ? 10'h009 : i == 3 ? 10'h000 : 10'h008, 2'h2, i == 5 ? w >> 8 : w & 16'h00ff);
      rd_chk(i == 6 ? 10'h009 : i == 3 ? 10'h000 : 10'h008, 2'h2, i == 5 ? w & 16'h00ff : w >> 8);
    end
    check_val(16'(ptr), 16'h0007);
    rd_chk(10'h000, 2'h1, {err_v, 8'h00});
    rd_chk(10'h00d, 2'h2, {8'h00, err_v});
    wr(10'h000, 2'h1, 16'h7700);
    check_val(16'(tf.features), 16'h0077);
    wr(10'h007, 2'h2, 16'h0030);
    wr(10'h000, 2'h0, 16'h1234);
    wr(10'h008, 2'h2, 16'h0056);
    wr(10'h009, 2'h2, 16'h0078);
    core_io(1'b0, 4'h0, 16'h0000);
    check_val(core_rd, 16'h1234);
    core_io(1'b0, 4'h1, 16'h0000);
    check_val(core_rd, 16'h7856);
    report_and_stop();
  end
endmodule : tfd_task_file_io_tb_top
`default_nettype wire
